// >>> verilog/cpu_register_set.v
// Behaviour
// - Twenty-one registers: eight general, seven address, status, config, four debug.
// - All registers 32 bits except module pointer and status word, 16 bits.
// - Byte or word operands on general registers touch only low bits.
// - Program counter holds address of first byte of current instruction.
// - Stack select 0 picks interrupt stack pointer, 1 picks user stack pointer.
// - Privileged load/store reach user stack pointer directly regardless of select flag.
// - Push pre-decrements active pointer by length; pop post-increments by length.
// - Module pointer is 16 bits, descriptors lie in lowest 64 kbytes.
// - Status word low half open to all; high half supervisor only (a user-mode store still returns the high half).
// - Carry set on carry or borrow, else cleared; used by carry arithmetic.
// - Trace enable set causes a trace trap after every instruction (not one started in the cycle a traced one is done).
// - Integer compare sets unsigned-less when second operand below first unsigned.
// - Floating compare always clears unsigned-less flag.
// - Overflow trap enable raises overflow trap on integer arithmetic overflow.
// - General condition flag updated by instructions, reports arithmetic overflow.
// - Compare sets zero flag when operands are equal, else clears it.
// - Compare sets negative flag when second operand below first, signed.
// - User mode refuses privileged instructions; supervisor mode permits all.
// - Entry to any interrupt or trap clears stack select flag.
// - Trace pending flag stops a second trace trap for one instruction.
// - Interrupt enable 1 accepts all interrupts, 0 only non-maskable; traps unaffected.
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`include "cpu_regs_defines.vh"

module cpu_register_set #(
  parameter [31:0] PC_RESET_VALUE = `PC_RESET
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // General register ports
  input wire [2:0] gp_rd_sel,
  input wire [1:0] gp_rd_size,
  output reg [31:0] gp_rd_data,
  input wire gp_wr_en,
  input wire [2:0] gp_wr_sel,
  input wire [1:0] gp_wr_size,
  input wire [31:0] gp_wr_data,
  // Program counter
  input wire pc_load,
  input wire [31:0] pc_next,
  output wire [31:0] program_counter,
  // Stack
  input wire stack_push,
  input wire stack_pop,
  input wire [3:0] stack_len,
  output wire [31:0] active_stack_pointer,
  // Processor register load and store
  input wire load_processor_register_op,
  input wire store_processor_register_op,
  input wire [4:0] proc_reg_sel,
  input wire [31:0] proc_reg_wdata,
  output reg [31:0] proc_reg_rdata,
  // Flag updates
  input wire arith_done,
  input wire arith_carry,
  input wire arith_overflow,
  input wire cmp_done,
  input wire cmp_float,
  input wire [31:0] cmp_first,
  input wire [31:0] cmp_second,
  input wire fcmp_equal,
  input wire fcmp_less,
  input wire flag_f_we,
  input wire flag_f_value,
  // Instruction and exception sequencing
  input wire instr_start,
  input wire instr_done,
  input wire privileged_op,
  input wire exception_entry,
  input wire irq_request,
  input wire nmi_request,
  output wire irq_accept,
  output wire nmi_accept,
  output reg trace_trap,
  output reg overflow_trap,
  output reg privilege_violation,
  // State views
  output wire [15:0] module_pointer,
  output wire [15:0] processor_status_word,
  output wire carry_flag,
  output wire user_mode
);

  reg [31:0] regs_q [0:`NUM_REGS-1];
  reg [4:0] bus_idx_q;
  reg bus_wr_q;
  reg bus_rd_q;
  reg bus_map_q;
  integer i;

  wire [31:0] psw = regs_q[`RIDX_PSW];
  wire user = psw[`PSW_U];
  wire [4:0] sp_idx = psw[`PSW_S] ? `RIDX_USP : `RIDX_ISP;
  wire [31:0] len_ext = {28'h0000000, stack_len};
  wire bus_req = hsel & htrans[1] & hready;
  wire bus_hit = (haddr[31:7] == 25'h0) && (haddr[6:2] < `NUM_REGS);
  wire [4:0] op_idx = (proc_reg_sel == `SEL_ACTIVE_SP) ? sp_idx : proc_reg_sel;
  wire op_mapped = (proc_reg_sel == `SEL_ACTIVE_SP) ||
                   ((proc_reg_sel >= `RIDX_PC) && (proc_reg_sel < `NUM_REGS));
  wire op_user_ok = (proc_reg_sel == `SEL_ACTIVE_SP) || (proc_reg_sel == `RIDX_FP) ||
                    (proc_reg_sel == `RIDX_SB) || (proc_reg_sel == `RIDX_MOD) ||
                    (proc_reg_sel == `RIDX_PSW);
  wire op_refused = user & ~op_user_ok;
  wire psw_high_change = user & load_processor_register_op & op_mapped & ~op_refused &
                         (op_idx == `RIDX_PSW) &
                         ((proc_reg_wdata[15:8] & 8'h0F) != psw[15:8]);

  // Keep only implemented bits of a register
  function [31:0] fit;
    input [4:0] idx;
    input [31:0] val;
    begin
      if (idx == `RIDX_PSW) begin
        fit = val & `PSW_WMASK;
      end else if (idx == `RIDX_MOD) begin
        fit = val & `HALF_MASK;
      end else begin
        fit = val;
      end
    end
  endfunction

  // Merge a narrow operand into the low part of a general register
  function [31:0] merge_low;
    input [31:0] old;
    input [31:0] val;
    input [1:0] size;
    begin
      case (size)
        `SIZE_BYTE: merge_low = {old[31:8], val[7:0]};
        `SIZE_WORD: merge_low = {old[31:16], val[15:0]};
        default: merge_low = val;
      endcase
    end
  endfunction

  // Bus address phase capture
  always @(posedge ref_clk) begin
    if (!resetn) begin
      bus_idx_q <= 5'h00;
      bus_wr_q <= 1'b0;
      bus_rd_q <= 1'b0;
      bus_map_q <= 1'b0;
    end else if (hready) begin
      bus_idx_q <= haddr[6:2];
      bus_wr_q <= bus_req & hwrite;
      bus_rd_q <= bus_req & ~hwrite;
      bus_map_q <= bus_req & bus_hit;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = (bus_rd_q & bus_map_q) ? regs_q[bus_idx_q] : 32'h00000000;

  // Register file; later assignments take precedence within a cycle
  always @(posedge ref_clk) begin
    if (!resetn) begin
      for (i = 0; i < `NUM_REGS; i = i + 1) begin
        regs_q[i] <= `REG_RESET;
      end
      regs_q[`RIDX_PC] <= PC_RESET_VALUE;
    end else begin
      if (bus_wr_q & bus_map_q) begin
        regs_q[bus_idx_q] <= fit(bus_idx_q, hwdata);
      end
      if (gp_wr_en) begin
        regs_q[{2'b00, gp_wr_sel}] <= merge_low(regs_q[{2'b00, gp_wr_sel}],
                                               gp_wr_data, gp_wr_size);
      end
      if (pc_load) begin
        regs_q[`RIDX_PC] <= pc_next;
      end
      if (load_processor_register_op & op_mapped & ~op_refused) begin
        if (user && (op_idx == `RIDX_PSW)) begin
          regs_q[`RIDX_PSW] <= {psw[31:8], proc_reg_wdata[7:0]} & `PSW_WMASK;
        end else begin
          regs_q[op_idx] <= fit(op_idx, proc_reg_wdata);
        end
      end
      if (stack_push) begin
        regs_q[sp_idx] <= regs_q[sp_idx] - len_ext;
      end else if (stack_pop) begin
        regs_q[sp_idx] <= regs_q[sp_idx] + len_ext;
      end
      if (arith_done) begin
        regs_q[`RIDX_PSW][`PSW_C] <= arith_carry;
        regs_q[`RIDX_PSW][`PSW_F] <= arith_overflow;
      end else if (flag_f_we) begin
        regs_q[`RIDX_PSW][`PSW_F] <= flag_f_value;
      end
      if (cmp_done) begin
        if (cmp_float) begin
          regs_q[`RIDX_PSW][`PSW_L] <= 1'b0;
          regs_q[`RIDX_PSW][`PSW_Z] <= fcmp_equal;
          regs_q[`RIDX_PSW][`PSW_N] <= fcmp_less;
        end else begin
          regs_q[`RIDX_PSW][`PSW_L] <= cmp_second < cmp_first;
          regs_q[`RIDX_PSW][`PSW_Z] <= cmp_second == cmp_first;
          regs_q[`RIDX_PSW][`PSW_N] <= $signed(cmp_second) < $signed(cmp_first);
        end
      end
      if (instr_done & psw[`PSW_P]) begin
        regs_q[`RIDX_PSW][`PSW_P] <= 1'b0;
      end else if (instr_start) begin
        regs_q[`RIDX_PSW][`PSW_P] <= psw[`PSW_T];
      end
      if (exception_entry) begin
        regs_q[`RIDX_PSW][`PSW_S] <= 1'b0;
      end
    end
  end

  // Registered read ports and event pulses
  always @(posedge ref_clk) begin
    if (!resetn) begin
      gp_rd_data <= 32'h00000000;
      proc_reg_rdata <= 32'h00000000;
      trace_trap <= 1'b0;
      overflow_trap <= 1'b0;
      privilege_violation <= 1'b0;
    end else begin
      case (gp_rd_size)
        `SIZE_BYTE: gp_rd_data <= {24'h000000, regs_q[{2'b00, gp_rd_sel}][7:0]};
        `SIZE_WORD: gp_rd_data <= {16'h0000, regs_q[{2'b00, gp_rd_sel}][15:0]};
        default: gp_rd_data <= regs_q[{2'b00, gp_rd_sel}];
      endcase
      if (store_processor_register_op) begin
        if (op_mapped & ~op_refused) begin
          proc_reg_rdata <= regs_q[op_idx];
        end else begin
          proc_reg_rdata <= 32'h00000000;
        end
      end
      trace_trap <= instr_done & psw[`PSW_P];
      overflow_trap <= arith_done & arith_overflow & psw[`PSW_V];
      privilege_violation <= (user & privileged_op) |
                             ((load_processor_register_op | store_processor_register_op) &
                              op_refused) |
                             psw_high_change;
    end
  end

  assign irq_accept = irq_request & psw[`PSW_I];
  assign nmi_accept = nmi_request;
  assign program_counter = regs_q[`RIDX_PC];
  assign active_stack_pointer = regs_q[sp_idx];
  assign module_pointer = regs_q[`RIDX_MOD][15:0];
  assign processor_status_word = psw[15:0];
  assign carry_flag = psw[`PSW_C];
  assign user_mode = user;

endmodule // cpu_register_set

// >>> inc/cpu_regs_defines.vh
`ifndef CPU_REGS_DEFINES_VH
`define CPU_REGS_DEFINES_VH

// Register indices; byte address on the bus is four times the index
`define NUM_REGS 21
`define RIDX_GP0 5'd0
`define RIDX_PC 5'd8
`define RIDX_ISP 5'd9
`define RIDX_USP 5'd10
`define RIDX_FP 5'd11
`define RIDX_SB 5'd12
`define RIDX_DISPATCH 5'd13
`define RIDX_MOD 5'd14
`define RIDX_PSW 5'd15
`define RIDX_CFG 5'd16
`define RIDX_DBG0 5'd17
`define RIDX_DBG3 5'd20

// Selector code for the currently active stack pointer
`define SEL_ACTIVE_SP 5'h1F

// Status word bit positions
`define PSW_C 0
`define PSW_T 1
`define PSW_L 2
`define PSW_V 4
`define PSW_F 5
`define PSW_Z 6
`define PSW_N 7
`define PSW_U 8
`define PSW_S 9
`define PSW_P 10
`define PSW_I 11

// Implemented bits and masks
`define PSW_WMASK 32'h00000FF7
`define PSW_HIGH_MASK 32'h0000FF00
`define HALF_MASK 32'h0000FFFF

// Reset values
`define PC_RESET 32'h00000000
`define REG_RESET 32'h00000000

// Operand sizes
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1

`endif

// >>> tb/cpu_regs_checker_assertions.sv
`timescale 1ns/1ns
module cpu_regs_checker (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Datapath requests
  input wire stack_push,
  input wire stack_pop,
  input wire [3:0] stack_len,
  input wire arith_done,
  input wire arith_carry,
  input wire arith_overflow,
  input wire cmp_done,
  input wire cmp_float,
  input wire [31:0] cmp_first,
  input wire [31:0] cmp_second,
  input wire instr_start,
  input wire instr_done,
  input wire privileged_op,
  input wire exception_entry,
  input wire irq_request,
  // Block outputs
  input wire [31:0] active_stack_pointer,
  input wire irq_accept,
  input wire trace_trap,
  input wire overflow_trap,
  input wire privilege_violation,
  input wire [15:0] processor_status_word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Traced instruction: start with trace enabled, done next cycle
  sequence s_traced;
    instr_start && processor_status_word[1] ##1 instr_done;
  endsequence
  AST_PUSH: assert property (stack_push && !exception_entry |=>
    active_stack_pointer == $past(active_stack_pointer) - $past(stack_len)) else $error("push");
  AST_POP: assert property (stack_pop && !stack_push && !exception_entry |=>
    active_stack_pointer == $past(active_stack_pointer) + $past(stack_len)) else $error("pop");
  AST_ARITH: assert property (arith_done |=> processor_status_word[0] == $past(arith_carry)
    && processor_status_word[5] == $past(arith_overflow)) else $error("carry or flag");
  AST_LESS: assert property (cmp_done |=> processor_status_word[2] ==
    (!$past(cmp_float) && $past(cmp_second) < $past(cmp_first))) else $error("less flag");
  AST_ZERO: assert property (cmp_done && !cmp_float |=>
    processor_status_word[6] == ($past(cmp_second) == $past(cmp_first))) else $error("zero");
  AST_NEG: assert property (cmp_done && !cmp_float |=> processor_status_word[7] ==
    ($signed($past(cmp_second)) < $signed($past(cmp_first)))) else $error("negative");
  AST_OVF: assert property (arith_done && arith_overflow && processor_status_word[4]
    |=> overflow_trap) else $error("overflow trap");
  AST_TRACE: assert property (s_traced |=> trace_trap) else $error("trace trap");
  AST_TRACE_ONCE: assert property (trace_trap |=> !trace_trap) else $error("trace twice");
  AST_PRIV: assert property (privileged_op && processor_status_word[8]
    |=> privilege_violation) else $error("privilege");
  AST_EXC: assert property (exception_entry |=> !processor_status_word[9])
    else $error("stack select");
  AST_IRQ: assert property (irq_accept == (irq_request && processor_status_word[11]))
    else $error("irq accept");
endmodule // cpu_regs_checker

// >>> tb/exec_model.sv
`timescale 1ns/1ns
module exec_model (
  // Clock
  input wire ref_clk,
  // Flag sources
  output reg arith_done,
  output reg arith_carry,
  output reg arith_overflow,
  output reg cmp_done,
  output reg cmp_float,
  output reg [31:0] cmp_first,
  output reg [31:0] cmp_second,
  output reg fcmp_equal,
  output reg fcmp_less,
  // Instruction sequencing
  output reg instr_start,
  output reg instr_done
);
  initial begin
    {arith_done, arith_carry, arith_overflow, cmp_done, cmp_float} = '0;
    {cmp_first, cmp_second, fcmp_equal, fcmp_less, instr_start, instr_done} = '0;
  end
  // Compare; f is float, equal, less; operands inverted once released
  task cmp(input [31:0] a, input [31:0] b, input [2:0] f);
    @(posedge ref_clk);
    {cmp_done, cmp_float, fcmp_equal, fcmp_less, cmp_first, cmp_second} <= {1'b1, f, a, b};
    @(posedge ref_clk);
    cmp_done <= 1'b0;
    {cmp_first, cmp_second} <= ~{a, b};
  endtask
  task arith(input c, input o);
    @(posedge ref_clk);
    {arith_done, arith_carry, arith_overflow} <= {1'b1, c, o};
    @(posedge ref_clk);
    {arith_done, arith_carry, arith_overflow} <= {1'b0, ~c, ~o};
  endtask
  task instr;
    @(posedge ref_clk);
    instr_start <= 1'b1;
    @(posedge ref_clk);
    {instr_start, instr_done} <= 2'h1;
    @(posedge ref_clk);
    instr_done <= 1'b0;
  endtask
endmodule // exec_model

// >>> tb/cpu_register_set_tb.sv
`timescale 1ns/1ns
module cpu_register_set_tb;
  reg ref_clk, resetn, hwrite, gp_wr_en, pc_load, stack_push, stack_pop, privileged_op;
  reg exception_entry, irq_request, nmi_request, load_processor_register_op;
  reg store_processor_register_op;
  reg [1:0] htrans, gp_wr_size, gp_rd_size;
  reg [2:0] gp_wr_sel, gp_rd_sel;
  reg [3:0] stack_len;
  reg [4:0] proc_reg_sel;
  reg [31:0] haddr, hwdata, gp_wr_data, pc_next, proc_reg_wdata, rd;
  integer n_fail, n_tests;
  integer n_trc = 0, n_ovf = 0, n_viol = 0;
  wire hsel = 1'b1;
  wire [2:0] hsize = 3'h2;
  wire flag_f_we = 1'b0, flag_f_value = 1'b0;
  wire hready, hreadyout, hresp, irq_accept, nmi_accept, trace_trap, overflow_trap;
  wire privilege_violation, carry_flag, user_mode, arith_done, arith_carry, arith_overflow;
  wire cmp_done, cmp_float, fcmp_equal, fcmp_less, instr_start, instr_done;
  wire [15:0] module_pointer, processor_status_word;
  wire [31:0] hrdata, gp_rd_data, program_counter, active_stack_pointer, proc_reg_rdata;
  wire [31:0] cmp_first, cmp_second;
  assign hready = hreadyout;
  cpu_register_set u_dut (.*);
  exec_model u_model (.*);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Count event pulses from the block
  always @(posedge ref_clk) begin
    if (resetn) begin
      n_trc <= n_trc + trace_trap;
      n_ovf <= n_ovf + overflow_trap;
      n_viol <= n_viol + privilege_violation;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input w, input [31:0] a, input [31:0] d);
    @(posedge ref_clk);
    {htrans, hwrite, haddr} <= {2'h2, w, a};
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task tcmp(input [31:0] a, input [31:0] b, input [2:0] f, input [31:0] e);
    u_model.cmp(a, b, f);
    @(negedge ref_clk);
    chk({16'h0000, processor_status_word} & 32'h000000C4, e);
  endtask
  task finish_test;
    $display("counts: %0d compared, %0d failed", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail = n_fail + 1;
    finish_test;
  end
  initial begin
    n_fail = 0;
    n_tests = 0;
    {resetn, hwrite, htrans, haddr, hwdata, gp_wr_en, gp_wr_size, gp_wr_sel, gp_wr_data} = '0;
    {pc_load, pc_next, stack_push, stack_pop, stack_len, privileged_op, exception_entry} = '0;
    {load_processor_register_op, store_processor_register_op, proc_reg_sel, proc_reg_wdata} = '0;
    {irq_request, nmi_request, gp_rd_sel, gp_rd_size} = 7'h6C;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk({16'h0000, processor_status_word}, 32'h00000000);
    bus(1'b1, 32'h0000000C, 32'hA5A55A5A);
    @(posedge ref_clk);
    {gp_wr_en, gp_wr_sel, gp_wr_size, gp_wr_data} <= {6'h2D, 32'hFFFF2211};
    @(posedge ref_clk);
    {gp_wr_en, gp_wr_sel, gp_wr_size, gp_wr_data} <= {6'h2C, 32'hFFFFFF33};
    @(posedge ref_clk);
    {gp_wr_en, pc_load, pc_next} <= {2'h1, 32'h00001000};
    @(posedge ref_clk);
    pc_load <= 1'b0;
    bus(1'b0, 32'h0000000C, 32'h00000000);
    chk(rd, 32'hA5A52233);
    chk(gp_rd_data, 32'h00000033);
    chk(program_counter, 32'h00001000);
    bus(1'b1, 32'h00000038, 32'h12345678);
    bus(1'b0, 32'h00000038, 32'h00000000);
    chk(rd, 32'h00005678);
    chk({16'h0000, module_pointer}, 32'h00005678);
    bus(1'b0, 32'h00000054, 32'h00000000);
    chk(rd, 32'h00000000);
    $display("test registers done");
    bus(1'b1, 32'h00000024, 32'h00000100);
    bus(1'b1, 32'h00000028, 32'h00000200);
    @(posedge ref_clk);
    {stack_push, stack_len} <= 5'h14;
    @(posedge ref_clk);
    {stack_push, stack_pop, stack_len} <= 6'h12;
    @(posedge ref_clk);
    stack_pop <= 1'b0;
    @(negedge ref_clk);
    chk(active_stack_pointer, 32'h000000FE);
    bus(1'b1, 32'h0000003C, 32'h00000200);
    @(negedge ref_clk);
    chk(active_stack_pointer, 32'h00000200);
    @(posedge ref_clk);
    exception_entry <= 1'b1;
    @(posedge ref_clk);
    exception_entry <= 1'b0;
    @(negedge ref_clk);
    chk(active_stack_pointer, 32'h000000FE);
    $display("test stack done");
    tcmp(32'h00000005, 32'hFFFFFFFF, 3'h0, 32'h00000080);
    tcmp(32'hFFFFFFFF, 32'h00000005, 3'h0, 32'h00000004);
    tcmp(32'h00000007, 32'h00000007, 3'h0, 32'h00000040);
    tcmp(32'h00000010, 32'h00000001, 3'h5, 32'h00000080);
    $display("test compare done");
    bus(1'b1, 32'h0000003C, 32'h00000810);
    u_model.arith(1'b1, 1'b1);
    @(negedge ref_clk);
    chk({16'h0000, processor_status_word} & 32'h00000031, 32'h00000031);
    chk({31'h0, carry_flag}, 32'h00000001);
    chk({31'h0, irq_accept}, 32'h00000001);
    bus(1'b1, 32'h0000003C, 32'h00000002);
    @(negedge ref_clk);
    chk({30'h0, irq_accept, nmi_accept}, 32'h00000001);
    u_model.instr;
    repeat (2) @(negedge ref_clk);
    chk(n_trc, 32'h00000001);
    chk(n_ovf, 32'h00000001);
    $display("test flags done");
    @(posedge ref_clk);
    {store_processor_register_op, proc_reg_sel} <= {1'b1, 5'h0A};
    @(posedge ref_clk);
    store_processor_register_op <= 1'b0;
    @(negedge ref_clk);
    chk(proc_reg_rdata, 32'h00000200);
    bus(1'b1, 32'h0000003C, 32'h00000100);
    @(posedge ref_clk);
    privileged_op <= 1'b1;
    @(posedge ref_clk);
    {privileged_op, load_processor_register_op, proc_reg_sel, proc_reg_wdata} <= {7'h2F, 32'h1};
    @(posedge ref_clk);
    {load_processor_register_op, irq_request, nmi_request} <= 3'h0;
    @(negedge ref_clk);
    chk({16'h0000, processor_status_word}, 32'h00000101);
    chk({31'h0, user_mode}, 32'h00000001);
    @(negedge ref_clk);
    chk(n_viol, 32'h00000002);
    $display("test privilege done");
    finish_test;
  end
endmodule // cpu_register_set_tb
bind cpu_register_set cpu_regs_checker u_chk (.*);
